// >>> acs_channel_sequencer.sv
/*
 * Channel selection and result routing of a converter sequencer,
 * with an Avalon-MM register slave.
 * Assumes a converter core on sys_clk that takes convStart, samples the
 * source on convSource, and returns convDone with convData.
 */
// The placing of the registers and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
//Contract
// - Single mode: every conversion samples channel code
// - Single mode results fill slots 0-3 or 0-7
// - Multi four: upper code bits choose group
// - Multi eight: top code bit chooses bank
// - Slot readable in three formats by address
// - Control write restarts sequence, clears flags
// - Slot flag set at done, cleared by read
// - Counter shows next slot to write
// - Sequence flag set at first sequence end
module acs_channel_sequencer
    import acs_pkg::*;
#(
    parameter int DATA_WIDTH = 10
)(
    input  wire logic                  sys_clk,
    input  wire logic                  resetn,
    input  wire logic [7:0]            address,
    input  wire logic                  read,
    input  wire logic                  write,
    input  wire logic [31:0]           writedata,
    output var  logic [31:0]           readdata,
    output var  logic                  waitrequest,
    output var  logic                  convStart,
    output var  logic [3:0]            convSource,
    input  wire logic                  convDone,
    input  wire logic [DATA_WIDTH-1:0] convData
);
    // Bus state
    acs_bus_state_type busState_q, busState_d;
    logic [31:0]       rdData_q, rdData_d;     // Read data register
    logic              waitReq_q, waitReq_d;   // High except on answer cycle
    logic [7:0]        addr_q, addr_d;         // Latched address
    logic              isWrite_q, isWrite_d;   // Latched direction
    logic [31:0]       wData_q, wData_d;       // Latched write data

    // Sequencer state
    acs_seq_state_type seqState_q, seqState_d;
    logic [6:0]        ctrl_q, ctrl_d;         // Scan, multichannel_enable, eight, code
    logic              scf_q, scf_d;           // Sequence complete
    logic [7:0]        ccf_q, ccf_d;           // Slot complete flags
    logic [2:0]        ctr_q, ctr_d;           // Next slot to write
    logic              start_q, start_d;       // Start pulse to core
    logic [3:0]        src_q, src_d;           // Source to core

    logic [DATA_WIDTH-1:0] slotData;           // Registered slot read
    logic [15:0]           fmtView;            // Formatted result view
    logic                  ctrlWrite;          // Control write takes effect
    logic                  slotRead;           // Slot read completes
    logic                  storeEn;            // Result stored this cycle

    assign ctrlWrite = (busState_q == ACS_BUS_ACK) && isWrite_q && (addr_q == ACS_CTRL_OFS);
    assign slotRead  = (busState_q == ACS_BUS_ACK) && !isWrite_q && (addr_q >= ACS_RIGHT_BASE)
                       && (addr_q < ACS_LUNS_BASE + 8'h20);
    // A done pulse standing beside our own start pulse is from an aborted conversion
    assign storeEn   = (seqState_q == ACS_SEQ_WAIT) && convDone && !start_q && !ctrlWrite;

    // Result slots, routed by counter
    acs_result_store #(
        .DATA_WIDTH (DATA_WIDTH),
        .DEPTH      (8)
    ) u_store (
        .sys_clk    (sys_clk),
        .writeEn    (storeEn),
        .writeIdx   (ctr_q),
        .writeData  (convData),
        .readIdx    (address[4:2]),
        .readData_q (slotData)
    );

    // Result view chosen by address window
    always_comb
    begin
        fmtView = 16'h0000;
        if (addr_q >= ACS_LUNS_BASE)
        begin
            fmtView = {slotData, 6'h00};
        end
        else if (addr_q >= ACS_LSIGN_BASE)
        begin
            fmtView = {~slotData[9], slotData[8:0], 6'h00};
        end
        else
        begin
            fmtView = {6'h00, slotData};
        end
    end

    // Bus slave next state; answers on third edge after request
    always_comb
    begin
        busState_d = busState_q;
        rdData_d   = rdData_q;
        waitReq_d  = 1'b1;
        addr_d     = addr_q;
        isWrite_d  = isWrite_q;
        wData_d    = wData_q;
        unique case (busState_q)
            ACS_BUS_IDLE:
            begin
                // Latch request; memory read starts now
                if (read || write)
                begin
                    addr_d     = address;
                    isWrite_d  = write;
                    wData_d    = writedata;
                    busState_d = ACS_BUS_FETCH;
                end
            end
            ACS_BUS_FETCH:
            begin
                // Build read data; unmapped reads give zero
                rdData_d = 32'h0000_0000;
                if (addr_q == ACS_CTRL_OFS)
                begin
                    rdData_d = {25'h0, ctrl_q};
                end
                else if (addr_q == ACS_STAT_OFS)
                begin
                    rdData_d = {16'h0, scf_q, 4'h0, ctr_q, ccf_q};
                end
                else if (addr_q[1:0] == 2'b00 && addr_q >= ACS_RIGHT_BASE
                         && addr_q < ACS_LUNS_BASE + 8'h20)
                begin
                    rdData_d = {16'h0, fmtView};
                end
                waitReq_d  = 1'b0;
                busState_d = ACS_BUS_ACK;
            end
            ACS_BUS_ACK:
            begin
                busState_d = ACS_BUS_IDLE;
            end
        endcase
    end

    // Bus slave registers
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            busState_q <= ACS_BUS_IDLE;
            rdData_q   <= 32'h0000_0000;
            waitReq_q  <= 1'b1;
            addr_q     <= 8'h00;
            isWrite_q  <= 1'b0;
            wData_q    <= 32'h0000_0000;
        end
        else
        begin
            busState_q <= busState_d;
            rdData_q   <= rdData_d;
            waitReq_q  <= waitReq_d;
            addr_q     <= addr_d;
            isWrite_q  <= isWrite_d;
            wData_q    <= wData_d;
        end
    end

    // Sequencer next state
    always_comb
    begin
        seqState_d = seqState_q;
        ctrl_d     = ctrl_q;
        scf_d      = scf_q;
        ccf_d      = ccf_q;
        ctr_d      = ctr_q;
        start_d    = 1'b0;
        src_d      = src_q;
        // Read of a slot clears its flag; a set below overrides
        if (slotRead)
        begin
            ccf_d[addr_q[4:2]] = 1'b0;
        end
        if (ctrlWrite)
        begin
            // Any control write aborts and restarts from slot zero
            ctrl_d     = wData_q[6:0];
            scf_d      = 1'b0;
            ccf_d      = ACS_CCF_RST;
            ctr_d      = ACS_CTR_RST;
            seqState_d = ACS_SEQ_START;
        end
        else
        begin
            unique case (seqState_q)
                ACS_SEQ_IDLE:
                begin
                    seqState_d = ACS_SEQ_IDLE;
                end
                ACS_SEQ_START:
                begin
                    // Pick source from mode, code and counter
                    if (!ctrl_q[ACS_MULTICHANNEL_ENABLE_BIT])
                    begin
                        src_d = ctrl_q[3:0];
                    end
                    else if (!ctrl_q[ACS_EIGHT_BIT])
                    begin
                        src_d = {ctrl_q[3:2], ctr_q[1:0]};
                    end
                    else
                    begin
                        src_d = {ctrl_q[3], ctr_q};
                    end
                    start_d    = 1'b1;
                    seqState_d = ACS_SEQ_WAIT;
                end
                ACS_SEQ_WAIT:
                begin
                    // Core cannot answer in the start cycle; such a done is stale
                    if (convDone && !start_q)
                    begin
                        ccf_d[ctr_q] = 1'b1;
                        if (ctr_q == (ctrl_q[ACS_EIGHT_BIT] ? ACS_LAST_OF_EIGHT
                                                            : ACS_LAST_OF_FOUR))
                        begin
                            // Sticky: stays set through further scans
                            scf_d      = 1'b1;
                            ctr_d      = ACS_CTR_RST;
                            seqState_d = ctrl_q[ACS_SCAN_BIT] ? ACS_SEQ_START
                                                              : ACS_SEQ_IDLE;
                        end
                        else
                        begin
                            ctr_d      = ctr_q + 3'h1;
                            seqState_d = ACS_SEQ_START;
                        end
                    end
                end
            endcase
        end
    end

    // Sequencer registers
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            seqState_q <= ACS_SEQ_IDLE;
            ctrl_q     <= ACS_CTRL_RST;
            scf_q      <= 1'b0;
            ccf_q      <= ACS_CCF_RST;
            ctr_q      <= ACS_CTR_RST;
            start_q    <= 1'b0;
            src_q      <= 4'h0;
        end
        else
        begin
            seqState_q <= seqState_d;
            ctrl_q     <= ctrl_d;
            scf_q      <= scf_d;
            ccf_q      <= ccf_d;
            ctr_q      <= ctr_d;
            start_q    <= start_d;
            src_q      <= src_d;
        end
    end

    // Outputs straight from flops
    assign readdata    = rdData_q;
    assign waitrequest = waitReq_q;
    assign convStart   = start_q;
    assign convSource  = src_q;
endmodule : acs_channel_sequencer
`default_nettype wire

// >>> acs_conv_model.sv
/* Behavioural converter core answering the sequencer.
   Assumes sys_clk and resetn shared with the sequencer. */
`timescale 1ns/100ps
`default_nettype none
module acs_conv_model
    import acs_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    input  wire logic       convStart,
    input  wire logic [3:0] convSource,
    input  wire logic [2:0] latency,
    output var  logic       convDone,
    output var  logic [9:0] convData
);
    logic       busyQ; // Conversion in flight
    logic [2:0] cntQ;  // Cycles left
    logic [3:0] srcQ;  // Source sampled at start
    // Result tags the source so routing shows in each slot
    always_ff @(posedge sys_clk)
    begin
        convDone <= 1'b0;
        // Data toggles outside a done pulse, so a value taken one cycle after the pulse never matches
        convData <= ~convData;
        if (!resetn)
        begin
            busyQ <= 1'b0;
            convData <= 10'h155;
        end
        else if (convStart)
        begin
            busyQ <= 1'b1;
            cntQ <= latency;
            srcQ <= convSource;
        end
        else if (busyQ && cntQ == 3'h0)
        begin
            busyQ <= 1'b0;
            convDone <= 1'b1;
            convData <= {srcQ, ~srcQ, 2'b10};
        end
        else if (busyQ)
            cntQ <= cntQ - 3'h1;
    end
endmodule : acs_conv_model
`default_nettype wire

// >>> acs_pkg.sv
/*
 * Constants and types shared by the channel sequencer and its result store.
 * Assumes a 32-bit Avalon-MM register bus with byte addresses.
 */
package acs_pkg;
    // Register byte offsets
    localparam logic [7:0] ACS_CTRL_OFS    = 8'h00; // Conversion control
    localparam logic [7:0] ACS_STAT_OFS    = 8'h04; // Sequence status
    localparam logic [7:0] ACS_RIGHT_BASE  = 8'h40; // Right unsigned view, 8 words
    localparam logic [7:0] ACS_LSIGN_BASE  = 8'h60; // Left signed view, 8 words
    localparam logic [7:0] ACS_LUNS_BASE   = 8'h80; // Left unsigned view, 8 words

    // Control field positions
    localparam int ACS_SCAN_BIT   = 6;  // Continuous scan
    localparam int ACS_MULTICHANNEL_ENABLE_BIT   = 5;  // Multichannel enable
    localparam int ACS_EIGHT_BIT  = 4;  // Eight-conversion select
    localparam int ACS_CODE_LSB   = 0;  // Channel code, 4 bits

    // Status field positions
    localparam int ACS_SCF_BIT    = 15; // Sequence complete
    localparam int ACS_CTR_LSB    = 8;  // Conversion counter, 3 bits
    localparam int ACS_CCF_LSB    = 0;  // Slot complete flags, 8 bits

    // Reset values
    localparam logic [6:0] ACS_CTRL_RST = 7'h00;
    localparam logic [7:0] ACS_CCF_RST  = 8'h00;
    localparam logic [2:0] ACS_CTR_RST  = 3'h0;

    // Sequence lengths, last counter value
    localparam logic [2:0] ACS_LAST_OF_FOUR  = 3'h3;
    localparam logic [2:0] ACS_LAST_OF_EIGHT = 3'h7;

    // Bus slave states
    typedef enum logic [2:0] {
        ACS_BUS_IDLE  = 3'b001,
        ACS_BUS_FETCH = 3'b010,
        ACS_BUS_ACK   = 3'b100
    } acs_bus_state_type;

    // Sequencer states
    typedef enum logic [2:0] {
        ACS_SEQ_IDLE  = 3'b001,
        ACS_SEQ_START = 3'b010,
        ACS_SEQ_WAIT  = 3'b100
    } acs_seq_state_type;
endpackage : acs_pkg

// >>> acs_result_store.sv
/*
 * Eight result slots of converter data, one write port, one read port.
 * Read data come from a register one clock after the read address.
 */
`timescale 1ns/100ps
`default_nettype none
module acs_result_store
    import acs_pkg::*;
#(
    parameter int DATA_WIDTH = 10,
    parameter int DEPTH      = 8
)(
    input  wire logic                     sys_clk,
    input  wire logic                     writeEn,
    input  wire logic [$clog2(DEPTH)-1:0] writeIdx,
    input  wire logic [DATA_WIDTH-1:0]    writeData,
    input  wire logic [$clog2(DEPTH)-1:0] readIdx,
    output var  logic [DATA_WIDTH-1:0]    readData_q
);
    logic [DATA_WIDTH-1:0] slotMem [DEPTH]; // Slot storage, no reset needed

    // Write and registered read
    always_ff @(posedge sys_clk)
    begin
        if (writeEn)
        begin
            slotMem[writeIdx] <= writeData;
        end
        readData_q <= slotMem[readIdx];
    end
endmodule : acs_result_store
`default_nettype wire

// >>> acs_seq_asserts.sv
/* Port checker of the channel sequencer.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/100ps
`default_nettype none
module acs_seq_asserts
    import acs_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        resetn,
    input wire logic [7:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    input wire logic        convStart,
    input wire logic [3:0]  convSource
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    logic [6:0] ctrlQ; // Last control word accepted
    logic [6:0] ctrlD;
    logic       ctrlAck; // Control write taking effect
    logic       rdAck;   // Read answered
    assign ctrlAck = write && !waitrequest && address == ACS_CTRL_OFS;
    assign rdAck = read && !waitrequest;
    always_comb ctrlD = ctrlAck ? writedata[6:0] : ctrlQ;
    always_ff @(posedge sys_clk)
        ctrlQ <= !resetn ? ACS_CTRL_RST : ctrlD;
    ack_one_cycle_a: assert property (!waitrequest |=> waitrequest)
        else $error("answer held too long");
    ack_bounded_a: assert property ((read || write) && waitrequest |-> ##[1:2] !waitrequest)
        else $error("answer late");
    single_source_a: assert property (convStart && !ctrlQ[5] |-> convSource == ctrlQ[3:0])
        else $error("single source wrong");
    four_group_a: assert property (convStart && ctrlQ[5] && !ctrlQ[4] |-> convSource[3:2] == ctrlQ[3:2])
        else $error("group wrong");
    eight_bank_a: assert property (convStart && ctrlQ[5] && ctrlQ[4] |-> convSource[3] == ctrlQ[3])
        else $error("bank wrong");
    source_hold_a: assert property (!convStart |=> convStart || $stable(convSource))
        else $error("source moved");
    restart_start_a: assert property (ctrlAck |-> ##2 convStart)
        else $error("no restart");
    unmapped_zero_a: assert property (rdAck && address inside {[8'h08:8'h3c], [8'ha0:8'hff]}
        |-> readdata == 32'h0)
        else $error("unmapped read not zero");
    status_pad_a: assert property (rdAck && address == ACS_STAT_OFS
        |-> readdata[31:16] == 16'h0 && readdata[14:11] == 4'h0)
        else $error("status padding set");
endmodule : acs_seq_asserts
bind acs_channel_sequencer acs_seq_asserts i_chk (.sys_clk(sys_clk), .resetn(resetn),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .convStart(convStart),
    .convSource(convSource));
`default_nettype wire

// >>> tb_top.sv
/* Self-checking bench of the channel sequencer with a converter model.
   Assumes a 100 MHz clock and nothing else around it. */
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import acs_pkg::*;
;
    logic sys_clk, resetn, read, write, waitrequest, convStart, convDone;
    logic [7:0]  address;
    logic [31:0] writedata, readdata, rng, s;
    logic [3:0]  convSource;
    logic [9:0]  convData;
    logic [2:0]  latency;
    logic [6:0]  corner [9] = '{7'h0c, 7'h0d, 7'h1e, 7'h20, 7'h24, 7'h28, 7'h2c, 7'h30, 7'h38};
    int mismatches = 0, cmp_count = 0, cycles = 0;
    acs_channel_sequencer i_dut (.sys_clk(sys_clk), .resetn(resetn), .address(address),
        .read(read), .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .convStart(convStart), .convSource(convSource),
        .convDone(convDone), .convData(convData));
    acs_conv_model i_core (.sys_clk(sys_clk), .resetn(resetn), .convStart(convStart),
        .convSource(convSource), .latency(latency), .convDone(convDone), .convData(convData));
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // Hang guard, far above the expected few thousand cycles
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            mismatches++;
            summarize();
        end
    end
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction : xs
    // Source expected for slot k under control word c
    function automatic logic [3:0] expSrc(input logic [6:0] c, input logic [2:0] k);
        if (!c[5])
            return c[3:0];
        return c[4] ? {c[3], k} : {c[3:2], k[1:0]};
    endfunction : expSrc
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : check
    // Request held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        address <= a;
        writedata <= d;
        write <= w;
        read <= !w;
        do @(posedge sys_clk); while (waitrequest !== 1'b0);
        s = readdata;
        write <= 1'b0;
        read <= 1'b0;
    endtask : bus
    task automatic waitDone();
        int i;
        i = 0;
        s = 32'h0;
        while (s[15] !== 1'b1 && i < 300)
        begin
            bus(1'b0, ACS_STAT_OFS, 32'h0);
            i++;
        end
    endtask : waitDone
    task automatic runSeq(input logic [6:0] c);
        logic [9:0] d;
        bus(1'b1, ACS_CTRL_OFS, 32'(c));
        waitDone();
        check("status", c[4] ? 32'h80ff : 32'h800f, s);
        for (int k = 0; k < (c[4] ? 8 : 4); k++)
        begin
            d = {expSrc(c, 3'(k)), ~expSrc(c, 3'(k)), 2'b10};
            bus(1'b0, ACS_RIGHT_BASE + 8'(4 * k), 32'h0);
            check("right view", 32'(d), s);
            bus(1'b0, ACS_LUNS_BASE + 8'(4 * k), 32'h0);
            check("left view", 32'({d, 6'h0}), s);
            bus(1'b0, ACS_LSIGN_BASE + 8'(4 * k), 32'h0);
            check("signed view", 32'({~d[9], d[8:0], 6'h0}), s);
        end
        bus(1'b0, ACS_STAT_OFS, 32'h0);
        check("flags read", 32'h8000, s);
    endtask : runSeq
    task automatic summarize();
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : summarize
    initial
    begin
        {resetn, read, write, address, writedata} = '0;
        latency = 3'h2;
        rng = 32'd44;
        repeat (4) @(posedge sys_clk);
        resetn <= 1'b1;
        bus(1'b0, ACS_STAT_OFS, 32'h0);
        check("reset status", 32'h0, s);
        bus(1'b0, 8'h20, 32'h0);
        check("unmapped", 32'h0, s);
        for (int i = 0; i < 20; i++)
        begin
            rng = xs(rng);
            latency <= rng[9:7];
            runSeq(i < 9 ? corner[i] : {1'b0, rng[5:0]});
        end
        // Continuous scan keeps the sequence flag up
        bus(1'b1, ACS_CTRL_OFS, 32'h4c);
        waitDone();
        bus(1'b0, ACS_STAT_OFS, 32'h0);
        check("scan flag", 32'h1, 32'(s[15]));
        // Slow core, abort mid-sequence
        latency <= 3'h7;
        bus(1'b1, ACS_CTRL_OFS, 32'h10);
        do bus(1'b0, ACS_STAT_OFS, 32'h0); while (s[7:0] == 8'h0 && cycles < 30000);
        check("mid status", 32'h0000_0101, s);
        bus(1'b1, ACS_CTRL_OFS, 32'h10);
        bus(1'b0, ACS_STAT_OFS, 32'h0);
        check("abort flags", 32'h0, s);
        runSeq(7'h30);
        summarize();
    end
endmodule : tb_top
`default_nettype wire
